// file: inc/remap_pkg.sv
// Package for the interrupt remapping engine: request, entry and result layouts
package remap_pkg;

  // Interrupt window and request address fields
  localparam logic [11:0] INTR_WINDOW     = 12'hFEE;
  localparam int          ADDR_ID_HI      = 31;
  localparam int          ADDR_ID_LO      = 20;
  localparam int          ADDR_HANDLE_HI  = 19;
  localparam int          ADDR_HANDLE_LO  = 5;
  localparam int          ADDR_FORMAT_BIT = 4;
  localparam int          ADDR_SHV_BIT    = 3;
  localparam int          ADDR_HANDLE15   = 2;
  localparam logic [3:0]  DWORD_BE        = 4'hF;

  // Entry size and table limits
  localparam int          ENTRY_BITS      = 128;
  localparam int          ENTRY_BYTES_LG  = 4;
  localparam int          INDEX_BITS      = 16;
  localparam int          ADDR_BITS       = 64;
  localparam logic [16:0] MAX_ENTRIES     = 17'h10000;

  // Fault reason codes
  localparam logic [7:0] FAULT_REQ_RSVD   = 8'h20;
  localparam logic [7:0] FAULT_BOUNDS     = 8'h21;
  localparam logic [7:0] FAULT_NOT_VALID  = 8'h22;
  localparam logic [7:0] FAULT_TABLE_ERR  = 8'h23;
  localparam logic [7:0] FAULT_ENTRY_RSVD = 8'h24;
  localparam logic [7:0] FAULT_COMPAT     = 8'h25;
  localparam logic [7:0] FAULT_SOURCE     = 8'h26;
  localparam logic [7:0] FAULT_DESC_ERR   = 8'h27;
  localparam logic [7:0] FAULT_DESC_RSVD  = 8'h28;

  // Entry field positions (remappable layout, simplified)
  localparam int ENT_VALID      = 0;
  localparam int ENT_REPORT_OFF = 1;
  localparam int ENT_DEST_MODE  = 2;
  localparam int ENT_REDIR_HINT = 3;
  localparam int ENT_TRIG_MODE  = 4;
  localparam int ENT_DELIV_LO   = 5;
  localparam int ENT_DELIV_HI   = 7;
  localparam int ENT_RSVD_LO    = 8;
  localparam int ENT_RSVD_HI    = 14;
  localparam int ENT_POSTED     = 15;
  localparam int ENT_VECTOR_LO  = 16;
  localparam int ENT_VECTOR_HI  = 23;
  localparam int ENT_RSVD2_LO   = 24;
  localparam int ENT_RSVD2_HI   = 31;
  localparam int ENT_DEST_LO    = 32;
  localparam int ENT_DEST_HI    = 63;
  localparam int ENT_SID_LO     = 64;
  localparam int ENT_SID_HI     = 79;
  localparam int ENT_SQ_LO      = 80;
  localparam int ENT_SQ_HI      = 81;
  localparam int ENT_SVT_LO     = 82;
  localparam int ENT_SVT_HI     = 83;
  localparam int ENT_RSVD3_LO   = 84;
  localparam int ENT_RSVD3_HI   = 127;

  // Source check types and delivery mode values
  localparam logic [1:0] SVT_NONE  = 2'h0;
  localparam logic [1:0] SVT_FULL  = 2'h1;
  localparam logic [1:0] SVT_BUS   = 2'h2;
  localparam logic [2:0] DELIV_RSV = 3'h3;

  // Incoming interrupt write request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  byte_en;
    logic [15:0] source_id;
  } intr_req_t;

  // Table configuration, from table_base_size and capability bits
  typedef struct packed {
    logic [51:0] base;
    logic [16:0] entry_count;
    logic [6:0]  host_addr_width;
    logic        walk_snoops;
    logic        memtype_support;
  } table_cfg_t;

  // Memory read request for one whole entry
  typedef struct packed {
    logic [63:0] addr;
    logic        no_snoop;
    logic        write_back;
  } fetch_req_t;

  // Remapped interrupt toward the processor interrupt bus
  typedef struct packed {
    logic [31:0] dest;
    logic [7:0]  vector;
    logic [2:0]  deliv_mode;
    logic        dest_mode;
    logic        redir_hint;
    logic        trig_mode;
    logic        trig_level;
  } remap_out_t;

  // Fault record visible to software
  typedef struct packed {
    logic [7:0]  reason;
    logic [15:0] source_id;
    logic [15:0] index;
  } fault_rec_t;

endpackage : remap_pkg

// file: rtl/entry_checker.sv
// Combinational checks of a fetched table entry against the requester
`timescale 1ns/1ns
module entry_checker
  import remap_pkg::*;
(
  input  wire logic [ENTRY_BITS-1:0] entry,
  input  wire logic [15:0]           source_id,
  output logic                       valid,
  output logic                       report_off,
  output logic                       posted,
  output logic                       source_ok,
  output logic                       rsvd_ok,
  output remap_pkg::remap_out_t      remapped
);
  logic [1:0]  source_check_type;
  logic [1:0]  sq;
  logic [15:0] source_id_value;
  logic [15:0] mask;

  // Source check per type and qualifier
  always_comb
  begin
    source_check_type        = entry[ENT_SVT_HI:ENT_SVT_LO];
    sq         = entry[ENT_SQ_HI:ENT_SQ_LO];
    source_id_value        = entry[ENT_SID_HI:ENT_SID_LO];
    valid      = entry[ENT_VALID];
    report_off = entry[ENT_REPORT_OFF];
    posted     = entry[ENT_POSTED];
    mask       = 16'hFFFF;
    unique case (sq)
      2'h1:    mask = 16'hFFFB;
      2'h2:    mask = 16'hFFF9;
      2'h3:    mask = 16'hFFF8;
      default: mask = 16'hFFFF;
    endcase
    unique case (source_check_type)
      SVT_NONE: source_ok = 1'b1;
      SVT_FULL: source_ok = ((source_id ^ source_id_value) & mask) == 16'h0000;
      SVT_BUS:  source_ok = (source_id[15:8] >= source_id_value[15:8]) && (source_id[15:8] <= source_id_value[7:0]);
      default:  source_ok = 1'b0;
    endcase
    // Reserved fields and a reserved delivery mode clear rsvd_ok
    rsvd_ok = (entry[ENT_RSVD_HI:ENT_RSVD_LO] == '0) && (entry[ENT_RSVD2_HI:ENT_RSVD2_LO] == '0)
            && (entry[ENT_RSVD3_HI:ENT_RSVD3_LO] == '0)
            && (entry[ENT_DELIV_HI:ENT_DELIV_LO] != DELIV_RSV);
    remapped.dest       = entry[ENT_DEST_HI:ENT_DEST_LO];
    remapped.vector     = entry[ENT_VECTOR_HI:ENT_VECTOR_LO];
    remapped.deliv_mode = entry[ENT_DELIV_HI:ENT_DELIV_LO];
    remapped.dest_mode  = entry[ENT_DEST_MODE];
    remapped.redir_hint = entry[ENT_REDIR_HINT];
    remapped.trig_mode  = entry[ENT_TRIG_MODE];
    remapped.trig_level = 1'b1;
  end
endmodule : entry_checker

// file: rtl/interrupt_remap_engine.sv
// Interrupt remapping engine: decode, index, fetch, check, remap or fault
// How it works
// [R01] Only dword writes to FEE window are interrupts
// [R02] Table is flat array of 128-bit entries
// [R03] Index is handle, plus subhandle when valid
// [R04] Up to 64K entries; index at count errors
// [R05] Remapping off: every interrupt request passes as compatibility
// [R06] Compat blocked with 25h by mode bits
// [R07] Request reserved bits set give fault 20h
// [R08] Bounds or address width breach gives 21h
// [R09] Entry from cache or single whole read
// [R10] No snoop when walk_snoops clear
// [R11] Write-back type when memtype_support set
// [R12] Invalid entry gives qualified fault 22h
// [R13] Source mismatch gives qualified fault 26h
// [R14] Bad remappable entry gives qualified 24h
// [R15] Remapped output always has level asserted
// [R16] Table read error gives fault 23h
// [R17] Posted errors use 27h and 28h
// [R18] Qualified faults suppressed by fault_report_off
// [R19] Blocked requests complete as Unsupported Request
// [R20] Requester places handle, format, subhandle_valid bits
// [R21] Subhandle in low data, upper reserved
// [R22] Reported fault captured with source, index
`timescale 1ns/1ns
module interrupt_remap_engine
  import remap_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  req_valid,
  input  wire remap_pkg::intr_req_t  req,
  output logic                       req_ready,
  input  wire logic                  remap_enable_status,
  input  wire logic                  extended_intr_mode_on,
  input  wire logic                  compat_format_allow,
  input  wire remap_pkg::table_cfg_t table_base_size,
  input  wire logic                  cache_hit,
  input  wire logic [ENTRY_BITS-1:0] cache_entry,
  output logic                       fetch_valid,
  output remap_pkg::fetch_req_t      fetch,
  input  wire logic                  fetch_done,
  input  wire logic                  fetch_error,
  input  wire logic [ENTRY_BITS-1:0] fetch_data,
  input  wire logic                  posted_desc_error,
  input  wire logic                  posted_desc_rsvd,
  output logic                       pass_valid,
  output remap_pkg::intr_req_t       pass_req,
  output logic                       remap_valid,
  output remap_pkg::remap_out_t      remap_out,
  output logic                       unsupported_req,
  output logic                       fault_event,
  output remap_pkg::fault_rec_t      fault_record
);
  import remap_pkg::*;

  typedef enum {IDLE, LOOKUP, FETCH, CHECK, DONE} state_t;

  state_t                state;
  state_t                next_state;
  intr_req_t             held;
  intr_req_t             next_held;
  logic [15:0]           index;
  logic [15:0]           next_index;
  logic [ENTRY_BITS-1:0] entry;
  logic [ENTRY_BITS-1:0] next_entry;
  logic                  next_req_ready;
  logic                  next_fetch_valid;
  fetch_req_t            next_fetch;
  logic                  next_pass_valid;
  intr_req_t             next_pass_req;
  logic                  next_remap_valid;
  remap_out_t            next_remap_out;
  logic                  next_unsupported_req;
  logic                  next_fault_event;
  fault_rec_t            next_fault_record;
  logic                  e_valid;
  logic                  e_report_off;
  logic                  e_posted;
  logic                  e_source_ok;
  logic                  e_rsvd_ok;
  remap_out_t            e_remapped;
  logic [16:0]           sum_index;
  logic [63:0]           entry_addr;

  // Interrupt window decode: dword write with FEE in the top digits
  function automatic logic is_interrupt(input intr_req_t r);
    return (r.addr[ADDR_ID_HI:ADDR_ID_LO] == INTR_WINDOW) && (r.byte_en == DWORD_BE);
  endfunction : is_interrupt

  // Handle from address bits 19..5 and bit 2
  function automatic logic [15:0] handle_of(input intr_req_t r);
    return {r.addr[ADDR_HANDLE15], r.addr[ADDR_HANDLE_HI:ADDR_HANDLE_LO]};
  endfunction : handle_of

  entry_checker u_checker (
    .entry      (entry),
    .source_id  (held.source_id),
    .valid      (e_valid),
    .report_off (e_report_off),
    .posted     (e_posted),
    .source_ok  (e_source_ok),
    .rsvd_ok    (e_rsvd_ok),
    .remapped   (e_remapped)
  );

  // Index, entry address and next-state logic
  always_comb
  begin
    sum_index            = {1'b0, handle_of(held)} + {1'b0, held.data[15:0]};
    entry_addr           = {table_base_size.base, 12'h000} + {44'h0, index, 4'h0};
    next_state           = state;
    next_held            = held;
    next_index           = index;
    next_entry           = entry;
    next_req_ready       = 1'b0;
    next_fetch_valid     = 1'b0;
    next_fetch           = fetch;
    next_pass_valid      = 1'b0;
    next_pass_req        = pass_req;
    next_remap_valid     = 1'b0;
    next_remap_out       = remap_out;
    next_unsupported_req = 1'b0;
    next_fault_event     = 1'b0;
    next_fault_record    = fault_record;
    unique case (state)
      IDLE:
      begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready)
        begin
          next_req_ready = 1'b0;
          next_held      = req;
          if (!is_interrupt(req)) // [R01]
            next_state = IDLE;
          else if (!remap_enable_status || !req.addr[ADDR_FORMAT_BIT]) // [R05]
          begin
            next_pass_req = req;
            if (remap_enable_status && (extended_intr_mode_on || !compat_format_allow)) // [R06]
            begin
              next_unsupported_req = 1'b1;
              next_fault_event     = 1'b1;
              next_fault_record    = '{reason: FAULT_COMPAT, source_id: req.source_id, index: 16'h0000};
            end
            else
              next_pass_valid = 1'b1;
            next_state = DONE;
          end
          else
            next_state = LOOKUP;
        end
      end
      LOOKUP:
      begin
        // Subhandle used only when valid; upper data reserved then
        if (held.addr[ADDR_SHV_BIT] && (held.data[31:16] != 16'h0000)) // [R07] [R21]
        begin
          next_unsupported_req = 1'b1;
          next_fault_event     = 1'b1;
          next_fault_record    = '{reason: FAULT_REQ_RSVD, source_id: held.source_id, index: 16'h0000};
          next_state           = DONE;
        end
        else
        begin
          next_index = held.addr[ADDR_SHV_BIT] ? sum_index[15:0] : handle_of(held); // [R03]
          // Sum overflow past 64K, or index at or above count
          if ((held.addr[ADDR_SHV_BIT] && sum_index >= MAX_ENTRIES)
              || ({1'b0, next_index} >= table_base_size.entry_count)) // [R04] [R08]
          begin
            next_unsupported_req = 1'b1;
            next_fault_event     = 1'b1;
            next_fault_record    = '{reason: FAULT_BOUNDS, source_id: held.source_id, index: next_index};
            next_state           = DONE;
          end
          else
            next_state = FETCH;
        end
      end
      FETCH:
      begin
        if ((entry_addr >> table_base_size.host_addr_width) != 64'h0) // [R08]
        begin
          next_unsupported_req = 1'b1;
          next_fault_event     = 1'b1;
          next_fault_record    = '{reason: FAULT_BOUNDS, source_id: held.source_id, index: index};
          next_state           = DONE;
        end
        else if (cache_hit && !fetch_valid) // [R09]
        begin
          next_entry = cache_entry;
          next_state = CHECK;
        end
        else if (!fetch_valid)
        begin
          // One read request covering the whole 128-bit entry
          next_fetch_valid      = 1'b1; // [R02] [R09]
          next_fetch.addr       = entry_addr;
          next_fetch.no_snoop   = !table_base_size.walk_snoops; // [R10]
          next_fetch.write_back = table_base_size.memtype_support; // [R11]
        end
        else if (fetch_done && fetch_error) // [R16]
        begin
          next_unsupported_req = 1'b1;
          next_fault_event     = 1'b1;
          next_fault_record    = '{reason: FAULT_TABLE_ERR, source_id: held.source_id, index: index};
          next_state           = DONE;
        end
        else if (fetch_done)
        begin
          next_entry = fetch_data;
          next_state = CHECK;
        end
        else
          next_fetch_valid = 1'b1;
      end
      CHECK:
      begin
        next_unsupported_req        = 1'b1; // [R19]
        next_fault_record.source_id = held.source_id;
        next_fault_record.index     = index;
        // Qualified faults are reported only when the entry allows it
        next_fault_event = !e_report_off; // [R18]
        if (!e_valid) // [R12]
          next_fault_record.reason = FAULT_NOT_VALID;
        else if (!e_source_ok) // [R13]
          next_fault_record.reason = FAULT_SOURCE;
        else if (e_posted && posted_desc_error) // [R17]
          next_fault_record.reason = FAULT_DESC_ERR;
        else if (e_posted && posted_desc_rsvd) // [R17]
          next_fault_record.reason = FAULT_DESC_RSVD;
        else if (!e_posted && !e_rsvd_ok) // [R14]
          next_fault_record.reason = FAULT_ENTRY_RSVD;
        else
        begin
          next_unsupported_req = 1'b0;
          next_fault_event     = 1'b0;
          next_fault_record    = fault_record;
          next_remap_valid     = !e_posted;
          next_remap_out       = e_remapped; // [R15]
        end
        next_state = DONE;
      end
      DONE:
      begin
        next_req_ready = 1'b1;
        next_state     = IDLE;
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state           <= IDLE;
      held            <= '0;
      index           <= '0;
      entry           <= '0;
      req_ready       <= 1'b0;
      fetch_valid     <= 1'b0;
      fetch           <= '0;
      pass_valid      <= 1'b0;
      pass_req        <= '0;
      remap_valid     <= 1'b0;
      remap_out       <= '0;
      unsupported_req <= 1'b0;
      fault_event     <= 1'b0;
      fault_record    <= '0;
    end
    else
    begin
      state           <= next_state;
      held            <= next_held;
      index           <= next_index;
      entry           <= next_entry;
      req_ready       <= next_req_ready;
      fetch_valid     <= next_fetch_valid;
      fetch           <= next_fetch;
      pass_valid      <= next_pass_valid;
      pass_req        <= next_pass_req;
      remap_valid     <= next_remap_valid;
      remap_out       <= next_remap_out;
      unsupported_req <= next_unsupported_req;
      fault_event     <= next_fault_event;
      fault_record    <= next_fault_record; // [R22]
    end
  end

  // Assertions
  property p_level_set;
    @(posedge core_clk) disable iff (!reset_n) remap_valid |-> remap_out.trig_level;
  endproperty
  a_level_set: assert property (p_level_set) else $error("remapped level not asserted"); // [R15]

  property p_no_snoop;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(fetch_valid) |-> fetch.no_snoop == !table_base_size.walk_snoops;
  endproperty
  a_no_snoop: assert property (p_no_snoop) else $error("snoop attribute wrong"); // [R10]

  property p_wb;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(fetch_valid) |-> fetch.write_back == table_base_size.memtype_support;
  endproperty
  a_wb: assert property (p_wb) else $error("memory type wrong"); // [R11]

  property p_fault_ur;
    @(posedge core_clk) disable iff (!reset_n) fault_event |-> unsupported_req;
  endproperty
  a_fault_ur: assert property (p_fault_ur) else $error("fault without UR"); // [R19]

  property p_single_fetch;
    @(posedge core_clk) disable iff (!reset_n) $rose(fetch_valid) |=> $stable(fetch.addr);
  endproperty
  a_single_fetch: assert property (p_single_fetch) else $error("fetch address changed"); // [R09]

  property p_exclusive;
    @(posedge core_clk) disable iff (!reset_n) !(remap_valid && (pass_valid || unsupported_req));
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("remap with pass or block"); // [R19]

  property p_compat_block;
    @(posedge core_clk) disable iff (!reset_n)
      fault_event && fault_record.reason == FAULT_COMPAT |-> !pass_valid;
  endproperty
  a_compat_block: assert property (p_compat_block) else $error("blocked compat passed"); // [R06]

  property p_bounds;
    @(posedge core_clk) disable iff (!reset_n)
      state == FETCH |-> {1'b0, index} < table_base_size.entry_count;
  endproperty
  a_bounds: assert property (p_bounds) else $error("fetch out of bounds"); // [R04]

  c_remap: cover property (@(posedge core_clk) remap_valid);
  c_pass: cover property (@(posedge core_clk) pass_valid);
  c_fault: cover property (@(posedge core_clk) fault_event);
  c_mem_fetch: cover property (@(posedge core_clk) fetch_valid && fetch_done);
endmodule : interrupt_remap_engine

// file: verif/table_memory_model.sv
// Memory side of the remapping table: answers whole-entry reads
`timescale 1ns/1ns
module table_memory_model
  import remap_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  fetch_valid,
  input  wire remap_pkg::fetch_req_t fetch,
  input  wire logic                  slow,
  input  wire logic                  err_inject,
  output logic                       fetch_done,
  output logic                       fetch_error,
  output logic [ENTRY_BITS-1:0]      fetch_data
);
  logic [ENTRY_BITS-1:0] mem [0:255];
  remap_pkg::fetch_req_t last_fetch;
  int                    reads;
  int                    wait_cnt;
  int                    phase;

  // One read per request, answered promptly or late; data toggles every cycle except the answer cycle
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fetch_done <= 1'b0;
      fetch_error <= 1'b0;
      fetch_data <= '0;
      reads <= 0;
      wait_cnt <= 0;
      phase <= 0;
    end
    else
    begin
      fetch_done <= 1'b0;
      fetch_error <= 1'b0;
      fetch_data <= ~fetch_data;
      if (phase == 0 && fetch_valid)
      begin
        phase <= 1;
        reads <= reads + 1;
        last_fetch <= fetch;
        wait_cnt <= slow ? 9 : 0;
      end
      else if (phase == 1 && wait_cnt > 0)
        wait_cnt <= wait_cnt - 1;
      else if (phase == 1)
      begin
        fetch_done <= 1'b1;
        fetch_error <= err_inject;
        fetch_data <= mem[last_fetch.addr[11:4]];
        phase <= 2;
      end
      else if (phase == 2 && !fetch_valid)
        phase <= 0;
    end
  end
endmodule : table_memory_model

// file: verif/interrupt_remap_engine_tb_top.sv
// Self-checking bench of the interrupt remapping engine
`timescale 1ns/1ns
module interrupt_remap_engine_tb_top;
  import remap_pkg::*;
  logic core_clk, reset_n, req_valid, req_ready, remap_enable_status, extended_intr_mode_on, compat_format_allow;
  logic cache_hit, fetch_valid, fetch_done, fetch_error, posted_desc_error, posted_desc_rsvd;
  logic pass_valid, remap_valid, unsupported_req, fault_event, slow, err_inject;
  logic [ENTRY_BITS-1:0] cache_entry, fetch_data, good, e;
  remap_pkg::intr_req_t  req, pass_req;
  remap_pkg::table_cfg_t table_base_size;
  remap_pkg::fetch_req_t fetch;
  remap_pkg::remap_out_t remap_out;
  remap_pkg::fault_rec_t fault_record;
  logic [16:0]           exp_idx;
  logic [15:0]           cur_sid;
  logic [31:0]           seed, s2;
  int                    err_total, n_tests, k;

  // Every port meets the bench signal of the same name
  interrupt_remap_engine i_interrupt_remap_engine (.*);
  table_memory_model     i_table_memory_model (.*);

  // Clock generator
  always #25 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Build an entry from flags {valid, report_off, posted}
  function automatic logic [127:0] ent(logic [2:0] f, logic [1:0] source_check_type, logic [15:0] source_id_value, logic [2:0] dm,
                                       logic [31:0] r);
    logic [127:0] x;
    x = '0;
    x[ENT_VALID] = f[2];
    x[ENT_REPORT_OFF] = f[1];
    x[ENT_POSTED] = f[0];
    x[ENT_TRIG_MODE] = r[0];
    x[ENT_DEST_MODE] = r[1];
    x[ENT_REDIR_HINT] = r[2];
    x[ENT_DELIV_HI:ENT_DELIV_LO] = dm;
    x[ENT_VECTOR_HI:ENT_VECTOR_LO] = r[15:8];
    x[ENT_DEST_HI:ENT_DEST_LO] = {r[15:0], r[31:16]};
    x[ENT_SID_HI:ENT_SID_LO] = source_id_value;
    x[ENT_SVT_HI:ENT_SVT_LO] = source_check_type;
    return x;
  endfunction : ent

  // Expected outcome {fetched, kind none/pass/remap/blocked, reported, reason}
  function automatic logic [11:0] expect_of(logic [31:0] a, d, logic [3:0] be, logic [127:0] x,
                                            logic hit, ferr, perr, prsv);
    logic [63:0] ea;
    logic        q;
    exp_idx = {1'b0, a[ADDR_HANDLE15], a[ADDR_HANDLE_HI:ADDR_HANDLE_LO]} + (a[ADDR_SHV_BIT] ? {1'b0, d[15:0]} : 17'h0);
    ea = {table_base_size.base, 12'h000} + {43'h0, exp_idx, 4'h0};
    q = ~x[ENT_REPORT_OFF];
    if (a[ADDR_ID_HI:ADDR_ID_LO] !== INTR_WINDOW || be !== DWORD_BE) return 12'h000;
    if (!remap_enable_status || !a[ADDR_FORMAT_BIT])
      return (!remap_enable_status || (!extended_intr_mode_on && compat_format_allow)) ? 12'h200 : {4'h7, FAULT_COMPAT};
    if (a[ADDR_SHV_BIT] && d[31:16] != 16'h0) return {4'h7, FAULT_REQ_RSVD};
    if (exp_idx >= table_base_size.entry_count || (ea >> table_base_size.host_addr_width) != 64'h0)
      return {4'h7, FAULT_BOUNDS};
    if (!hit && ferr) return {4'hF, FAULT_TABLE_ERR};
    if (!x[ENT_VALID]) return {!hit, 2'b11, q, FAULT_NOT_VALID};
    if (x[ENT_SVT_HI:ENT_SVT_LO] == SVT_FULL && x[ENT_SID_HI:ENT_SID_LO] != cur_sid)
      return {!hit, 2'b11, q, FAULT_SOURCE};
    if (x[ENT_POSTED]) return perr ? {!hit, 2'b11, q, FAULT_DESC_ERR} : prsv ? {!hit, 2'b11, q, FAULT_DESC_RSVD} : {!hit, 11'h0};
    if ((|x[ENT_RSVD_HI:ENT_RSVD_LO]) || (|x[ENT_RSVD2_HI:ENT_RSVD2_LO]) || (|x[ENT_RSVD3_HI:ENT_RSVD3_LO])
        || x[ENT_DELIV_HI:ENT_DELIV_LO] == DELIV_RSV) return {!hit, 2'b11, q, FAULT_ENTRY_RSVD};
    return {!hit, 11'h400};
  endfunction : expect_of

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One request from an interrupt source, then the checks of its answer
  // Flags f are {cache hit, table error, descriptor error, descriptor reserved}
  task automatic run(input logic [31:0] a, d, input logic [127:0] x, input logic [3:0] f = 4'h0,
                     input logic [3:0] be = 4'hF);
    logic [11:0] r;
    logic [1:0]  kind;
    logic        fev;
    int          n, rd0;
    cache_entry <= x;
    {cache_hit, err_inject, posted_desc_error, posted_desc_rsvd} <= f;
    req <= {a, d, be, cur_sid};
    req_valid <= 1'b1;
    rd0 = i_table_memory_model.reads;
    @(posedge core_clk);
    r = expect_of(a, d, be, x, f[3], f[2], f[1], f[0]);
    i_table_memory_model.mem[exp_idx[7:0]] = x;
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    req_valid <= 1'b0;
    kind = 2'd0;
    fev = 1'b0;
    for (n = 0; n < 40 && kind == 2'd0; n++)
    begin
      @(posedge core_clk);
      fev |= fault_event;
      kind = pass_valid ? 2'd1 : remap_valid ? 2'd2 : unsupported_req ? 2'd3 : 2'd0;
      if (kind == 2'd1) check("pass_req", pass_req, {a, d, be, cur_sid});
      if (kind == 2'd2) check("remap_out", remap_out, {x[63:32], x[23:16], x[7:5], x[2], x[3], x[4], 1'b1});
    end
    @(posedge core_clk);
    fev |= fault_event;
    check("kind", kind, r[10:9]);
    check("fault_event", fev, r[8]);
    if (fev) check("fault_record", fault_record, {r[7:0], cur_sid, r[7:0] inside {FAULT_COMPAT, FAULT_REQ_RSVD} ? 16'h0 : exp_idx[15:0]});
    check("reads", i_table_memory_model.reads - rd0, r[11]);
    if (r[11]) check("fetch", i_table_memory_model.last_fetch, {{table_base_size.base, 12'h000} + {43'h0, exp_idx, 4'h0},
      ~table_base_size.walk_snoops, table_base_size.memtype_support});
    $display("test done: addr %h kind %0d", a, kind);
  endtask : run

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    core_clk = 0; reset_n = 0; req_valid = 0; req = '0; cache_hit = 0; cache_entry = '0;
    remap_enable_status = 1; extended_intr_mode_on = 0; compat_format_allow = 1;
    posted_desc_error = 0; posted_desc_rsvd = 0; slow = 0; err_inject = 0; err_total = 0; n_tests = 0;
    table_base_size = {52'h10, 17'h100, 7'd48, 1'b0, 1'b1};
    cur_sid = 16'h0123; seed = 32'd75770;
    good = ent(3'b100, SVT_FULL, 16'h0123, 3'h0, 32'h1234_5678);
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    run(32'hFED0_0010, 0, good);
    run(32'hFEE0_0010, 0, good, 0, 4'h3);
    remap_enable_status <= 1'b0;
    run(32'hFEE0_0010, 0, good);
    remap_enable_status <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      extended_intr_mode_on <= k[1];
      compat_format_allow <= k[0];
      run(32'hFEE0_0000, 0, good);
    end
    extended_intr_mode_on <= 1'b0;
    compat_format_allow <= 1'b1;
    run(32'hFEE0_0018, 32'h0001_0002, good);
    table_base_size.entry_count <= 17'h10000;
    run(32'hFEEF_FFFC, 32'h1, good, 4'h8);
    run(32'hFEEF_FFF8, 32'h1, good, 4'h8);
    table_base_size.entry_count <= 17'h00100;
    slow <= 1'b1;
    run(32'hFEE0_1FF0, 0, good);
    run(32'hFEE0_2010, 0, good);
    table_base_size.host_addr_width <= 7'd16;
    run(32'hFEE0_0010, 0, good);
    table_base_size.host_addr_width <= 7'd48;
    run(32'hFEE0_0030, 0, ent(3'b000, SVT_NONE, 0, 0, 1));
    run(32'hFEE0_0030, 0, ent(3'b010, SVT_NONE, 0, 0, 1));
    run(32'hFEE0_0030, 0, ent(3'b100, SVT_FULL, 16'hBEEF, 0, 1), 4'h8);
    run(32'hFEE0_0030, 0, good | (128'h1 << ENT_RSVD_LO));
    run(32'hFEE0_0030, 0, ent(3'b100, SVT_NONE, 0, DELIV_RSV, 1), 4'h8);
    run(32'hFEE0_0030, 0, good, 4'h4);
    run(32'hFEE0_0030, 0, ent(3'b101, SVT_NONE, 0, 0, 1), 4'h2);
    run(32'hFEE0_0030, 0, ent(3'b101, SVT_NONE, 0, 0, 1), 4'h9);
    for (k = 0; k < 40; k++)
    begin
      seed = lfsr(seed);
      s2 = lfsr(lfsr(seed));
      cur_sid = seed[15:0];
      slow <= seed[16];
      table_base_size.walk_snoops <= seed[17];
      table_base_size.memtype_support <= seed[18];
      e = ent({2'b10, 1'b0}, seed[19] ? SVT_FULL : SVT_NONE, seed[15:0], {seed[22], 1'b0, seed[20]}, s2);
      run({12'hFEE, 7'h0, seed[30:23], 1'b1, seed[31], 3'h0}, {25'h0, s2[6:0]}, e, {s2[7], 3'h0});
    end
    tally_and_finish();
  end
endmodule : interrupt_remap_engine_tb_top
